// [srmd_defs.svh]
// Purpose: constants for the secured region mode decoder
// Assumes: word addressing, 16-bit data
// Notes: offsets relative to the device base
`ifndef SRMD_DEFS_SVH
`define SRMD_DEFS_SVH
`define SRMD_ADDR_W 24
`define SRMD_DATA_W 16
`define SRMD_UNLOCK1_ADDR 24'h000555
`define SRMD_UNLOCK2_ADDR 24'h0002AA
`define SRMD_UNLOCK1_DATA 16'h00AA
`define SRMD_UNLOCK2_DATA 16'h0055
`define SRMD_ENTER_DATA 16'h0088
`define SRMD_EXIT_DATA 16'h0090
`define SRMD_PROG_DATA 16'h00A0
`define SRMD_REGION_WORDS 256
`define SRMD_REGION_AW 8
`define SRMD_CUST_FIRST 8'h80
`define SRMD_SECTOR0_AW 14
`define SRMD_ERASED 16'hFFFF
`endif

// [srmd_pkg.sv]
// Purpose: types for the secured region mode decoder
// Assumes: nothing
// Notes: one-hot sequence states
package srmd_pkg;
  typedef enum logic [4:0] {
    SRMD_IDLE = 5'h01,
    SRMD_UNL1 = 5'h02,
    SRMD_UNL2 = 5'h04,
    SRMD_PROG = 5'h08,
    SRMD_HOLD = 5'h10
  } srmd_state_t;
endpackage

// [srmd_region_mem.sv]
// Purpose: 256-word secured region storage
// Assumes: factory area preloaded by strap-free default (erased)
// Notes: writes only land in the customer half
`timescale 1ns/1ps
`include "srmd_defs.svh"
module srmd_region_mem (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [`SRMD_REGION_AW-1:0] i_waddr,
  input wire logic [`SRMD_DATA_W-1:0] i_wdata,
  input wire logic [`SRMD_REGION_AW-1:0] i_raddr,
  output logic [`SRMD_DATA_W-1:0] o_rdata
);
  logic [`SRMD_DATA_W-1:0] mem [0:`SRMD_REGION_WORDS-1];
  wire cust_hit = (i_waddr >= `SRMD_CUST_FIRST);
  initial begin
    for (int k = 0; k < `SRMD_REGION_WORDS; k++) begin
      mem[k] = `SRMD_ERASED;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_we && cust_hit) begin
      mem[i_waddr] <= mem[i_waddr] & i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule // srmd_region_mem

// [srmd_decoder.sv]
// Purpose: secured region mode command decoder and read redirect
// Assumes: host write strobes already synchronous; array data from outside
// Notes: program only clears bits, like flash
// Function
// - AA/55/88 sequence enters secured mode
// - AA/55/90 sequence leaves secured mode
// - lowest sector reads return region data
// - mode holds until exit or reset
// - factory and customer areas both readable
// - AA/55/A0 then data programs customer word
// - no other access restores normal mapping
// - region 256 words, customer 80h-FFh
// - reset clears mode to normal mapping
// - region refused during embedded operation
// - out-of-range region reads flagged invalid
`timescale 1ns/1ps
`include "srmd_defs.svh"
module srmd_decoder (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [`SRMD_ADDR_W-1:0] i_addr,
  input wire logic [`SRMD_DATA_W-1:0] i_wdata,
  input wire logic i_embedded_busy,
  input wire logic [`SRMD_DATA_W-1:0] i_array_rdata,
  output logic o_secured_mode,
  output logic o_redirect,
  output logic o_rvalid,
  output logic [`SRMD_DATA_W-1:0] o_rdata,
  output logic o_rinvalid,
  output logic o_refused,
  output logic o_prog_done
);
  // ==========================================
  // decode
  // ==========================================
  srmd_pkg::srmd_state_t state;
  srmd_pkg::srmd_state_t next_state;
  logic next_mode;
  wire at_u1 = (i_addr == `SRMD_UNLOCK1_ADDR);
  wire at_u2 = (i_addr == `SRMD_UNLOCK2_ADDR);
  wire w_unl1 = i_wr && at_u1 && (i_wdata == `SRMD_UNLOCK1_DATA);
  wire w_unl2 = i_wr && at_u2 && (i_wdata == `SRMD_UNLOCK2_DATA);
  wire w_enter = i_wr && at_u1 && (i_wdata == `SRMD_ENTER_DATA);
  wire w_exit = i_wr && at_u1 && (i_wdata == `SRMD_EXIT_DATA);
  wire w_psetup = i_wr && at_u1 && (i_wdata == `SRMD_PROG_DATA) && o_secured_mode;
  wire in_sector0 = (i_addr[`SRMD_ADDR_W-1:`SRMD_SECTOR0_AW] == '0);
  wire in_region = (i_addr[`SRMD_SECTOR0_AW-1:`SRMD_REGION_AW] == '0);
  wire redirect = o_secured_mode && in_sector0;
  // factory half never takes a program write
  wire cust_addr = (i_addr[`SRMD_REGION_AW-1:0] >= `SRMD_CUST_FIRST);
  wire prog_we = (state == srmd_pkg::SRMD_PROG) && i_wr && redirect && in_region && cust_addr
                 && !i_embedded_busy;
  wire [`SRMD_DATA_W-1:0] mem_rdata;

  // ==========================================
  // sequence machine
  // ==========================================
  always_comb begin
    next_state = state;
    next_mode = o_secured_mode;
    case (state)
      srmd_pkg::SRMD_IDLE: begin
        if (w_unl1) begin
          next_state = srmd_pkg::SRMD_UNL1;
        end
      end
      srmd_pkg::SRMD_UNL1: begin
        if (i_wr) begin
          next_state = w_unl2 ? srmd_pkg::SRMD_UNL2 : srmd_pkg::SRMD_IDLE;
        end
      end
      srmd_pkg::SRMD_UNL2: begin
        if (i_wr) begin
          next_state = srmd_pkg::SRMD_IDLE;
          if (w_enter) begin
            next_mode = 1'b1;
          end else if (w_exit) begin
            next_mode = 1'b0;
          end else if (w_psetup) begin
            next_state = srmd_pkg::SRMD_PROG;
          end
        end
      end
      srmd_pkg::SRMD_PROG: begin
        if (i_wr) begin
          next_state = srmd_pkg::SRMD_IDLE;
        end
      end
      default: begin
        next_state = srmd_pkg::SRMD_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state <= srmd_pkg::SRMD_IDLE;
      o_secured_mode <= 1'b0;
    end else begin
      state <= next_state;
      o_secured_mode <= next_mode;
    end
  end

  // ==========================================
  // region storage
  // ==========================================
  srmd_region_mem u_mem (
    .i_clk(i_clk),
    .i_we(prog_we),
    .i_waddr(i_addr[`SRMD_REGION_AW-1:0]),
    .i_wdata(i_wdata),
    .i_raddr(i_addr[`SRMD_REGION_AW-1:0]),
    .o_rdata(mem_rdata)
  );

  // ==========================================
  // read path, one cycle after request
  // ==========================================
  logic rd_q;
  logic redir_q;
  logic inreg_q;
  logic busy_q;
  wire [`SRMD_DATA_W-1:0] sel_rdata = redir_q ? mem_rdata : i_array_rdata;
  assign o_redirect = redirect;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rd_q <= 1'b0;
      redir_q <= 1'b0;
      inreg_q <= 1'b0;
      busy_q <= 1'b0;
      o_prog_done <= 1'b0;
    end else begin
      rd_q <= i_rd;
      redir_q <= redirect;
      inreg_q <= in_region;
      busy_q <= i_embedded_busy;
      o_prog_done <= prog_we;
    end
  end
  assign o_rvalid = rd_q;
  assign o_rdata = (redir_q && (busy_q || !inreg_q)) ? `SRMD_ERASED : sel_rdata;
  assign o_rinvalid = rd_q && redir_q && !inreg_q;
  assign o_refused = rd_q && redir_q && busy_q;
endmodule // srmd_decoder

// [srmd_host.sv]
// Purpose: host bus and array model
// Assumes: one-cycle strobes
// Notes: idle array data toggles every cycle
`timescale 1ns/1ps
module srmd_host (
  input wire logic i_clk,
  output logic o_wr, o_rd, o_busy,
  output logic [23:0] o_addr,
  output logic [15:0] o_wdata, o_arr
);
  initial {o_wr, o_rd, o_busy, o_addr, o_wdata, o_arr} = '0;
  always @(posedge i_clk) o_arr <= o_rd ? {o_addr[7:0], ~o_addr[7:0]} : ~o_arr;
  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    @(posedge i_clk) {o_wr, o_addr, o_wdata} <= {1'b1, a, d};
    @(posedge i_clk) {o_wr, o_wdata} <= {1'b0, ~d};
    #1;
  endtask
  task automatic rd(input logic [23:0] a);
    @(posedge i_clk) {o_rd, o_addr} <= {1'b1, a};
    @(posedge i_clk) o_rd <= 1'b0;
    #1;
  endtask
endmodule // srmd_host

// [srmd_decoder_chk.sv]
// Purpose: port checker
// Assumes: bound to srmd_decoder
// Notes: one clock domain
`timescale 1ns/1ps
module srmd_decoder_chk (
  input wire logic i_clk, i_srst, i_wr, i_rd, i_embedded_busy,
  input wire logic [23:0] i_addr,
  input wire logic [15:0] i_wdata, i_array_rdata, o_rdata,
  input wire logic o_secured_mode, o_redirect, o_rvalid, o_rinvalid, o_refused, o_prog_done
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  chk_reset_clear: assert property ($past(i_srst) |-> !o_secured_mode && !o_rvalid) else $error("reset");
  chk_enter_cmd: assert property ($rose(o_secured_mode) |->
    $past(i_wr) && $past(i_wdata) == 16'h0088 && $past(i_addr) == 24'h000555) else $error("entry");
  chk_exit_cmd: assert property ($fell(o_secured_mode) |->
    $past(i_wr) && $past(i_wdata) == 16'h0090) else $error("exit");
  chk_redirect_map: assert property (o_redirect == (o_secured_mode && i_addr < 24'h004000)) else $error("map");
  chk_array_pass: assert property (o_rvalid && !$past(o_redirect) |->
    o_rdata == i_array_rdata) else $error("array");
  chk_refused_read: assert property (o_refused |->
    $past(i_embedded_busy) && $past(o_redirect) && o_rdata == 16'hFFFF) else $error("refuse");
  chk_range_flag: assert property (o_rinvalid |->
    $past(i_addr) > 24'h0000FF && o_rdata == 16'hFFFF) else $error("range");
  chk_prog_cause: assert property (o_prog_done |-> $past(i_wr) && $past(o_secured_mode) &&
    $past(i_addr) inside {[24'h000080:24'h0000FF]}) else $error("prog");
endmodule // srmd_decoder_chk
bind srmd_decoder srmd_decoder_chk u_chk (.*);

// [secure_region_mode_decoder_tb.sv]
// Purpose: self-checking bench
// Assumes: srmd_host drives the bus
// Notes: table first, then program and range, then busy and reset
`timescale 1ns/1ps
module secure_region_mode_decoder_tb;
  logic i_clk = 1'b0, i_srst = 1'b1;
  logic wr, rd, busy, mode, rv, rinv, refu, pdone, redir;
  logic [23:0] addr;
  logic [15:0] wdata, arr, rdata;
  int n_mismatch = 0, cmp_count = 0;
  typedef struct {int k; logic [23:0] a; logic [15:0] d, e;} srmd_row_t;
  // kind 0 unlock+command, 1 write, 2 read
  srmd_row_t rows[15] = '{'{0,0,16'h88,1}, '{2,16'h80,0,16'hFFFF}, '{2,16'h10,0,16'hFFFF},
    '{2,16'h4010,0,16'h10EF}, '{0,0,16'hA0,1}, '{1,16'h80,16'h1234,1}, '{2,16'h80,0,16'h1234},
    '{0,0,16'hA0,1}, '{1,16'h10,0,1}, '{2,16'h10,0,16'hFFFF}, '{0,0,16'h77,1}, '{1,0,16'h90,1},
    '{2,16'h100,0,16'hFFFF}, '{0,0,16'h90,0}, '{2,16'h80,0,16'h807F}};
  srmd_host h (.i_clk(i_clk), .o_wr(wr), .o_rd(rd), .o_busy(busy), .o_addr(addr), .o_wdata(wdata), .o_arr(arr));
  srmd_decoder dut (.i_clk(i_clk), .i_srst(i_srst), .i_wr(wr), .i_rd(rd), .i_addr(addr), .i_wdata(wdata),
    .i_embedded_busy(busy), .i_array_rdata(arr), .o_secured_mode(mode), .o_redirect(redir), .o_rvalid(rv),
    .o_rdata(rdata), .o_rinvalid(rinv), .o_refused(refu), .o_prog_done(pdone));
  task chk(input logic [15:0] s, e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task seq(input logic [15:0] c);
    h.wr(24'h000555, 16'h00AA);
    h.wr(24'h0002AA, 16'h0055);
    h.wr(24'h000555, c);
  endtask
  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial forever #25 i_clk = ~i_clk;
  initial begin
    #2000000 n_mismatch++;
    final_report;
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_srst <= 1'b0;
    #1 chk({15'h0000, mode}, 16'h0000);
    foreach (rows[i]) begin
      case (rows[i].k)
        0: seq(rows[i].d);
        1: h.wr(rows[i].a, rows[i].d);
        default: h.rd(rows[i].a);
      endcase
      chk(rows[i].k == 2 ? rdata : {15'h0000, mode}, rows[i].e);
      $display("row %0d done", i);
    end
    seq(16'h0088);
    seq(16'h00A0);
    h.wr(24'h000081, 16'h00F0);
    chk({15'h0000, pdone}, 16'h0001);
    h.rd(24'h000100);
    chk({15'h0000, rinv}, 16'h0001);
    chk({15'h0000, rv}, 16'h0001);
    chk({15'h0000, redir}, 16'h0001);
    h.rd(24'h000081);
    chk(rdata, 16'h00F0);
    $display("program and range done");
    @(posedge i_clk) h.o_busy <= 1'b1;
    h.rd(24'h000080);
    chk(rdata, 16'hFFFF);
    chk({15'h0000, refu}, 16'h0001);
    @(posedge i_clk) {h.o_busy, i_srst} <= 2'h1;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    #1 chk({15'h0000, mode}, 16'h0000);
    $display("busy and reset done");
    final_report;
  end
endmodule // secure_region_mode_decoder_tb
